// [qdrc_top.sv]
/*
  qdrc_top: device side of the queued DMA read command, with its
  command block reached over AXI4-Lite and a media engine on plain ports.
  Assumes the media engine runs on aclk and answers with pulses.
*/
`timescale 1ns/1ps
`default_nettype none
module qdrc_top
  import qdrc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [5:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [5:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        data_now,
  input  wire logic        prep_valid,
  input  wire logic [4:0]  prep_tag,
  input  wire logic        xfer_done,
  input  wire logic        xfer_fail,
  input  wire logic [7:0]  fail_bits,
  input  wire logic [27:0] fail_addr,
  input  wire logic        dev_fault,
  input  wire logic        media_changed,
  input  wire logic        media_chg_req,
  input  wire logic        no_media,
  output logic             cmd_req,
  output logic             dma_go,
  output logic             queue_flush,
  output logic [4:0]       dma_tag,
  output logic [27:0]      dma_lba,
  output logic [8:0]       dma_count,
  output logic             dma_lba_mode
);
  typedef struct packed {
    qdrc_state_t st;
    logic        awg;
    logic [5:0]  awa;
    logic        wg;
    logic [7:0]  wd;
    logic        wbe;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [7:0]  rd;
    logic [1:0]  rresp;
    logic [7:0]  opc;
    logic [7:0]  feat;
    logic [7:0]  irr;
    logic [7:0]  alow;
    logic [7:0]  amid;
    logic [7:0]  ahigh;
    logic [7:0]  devh;
    logic [7:0]  err;
    logic [7:0]  ctrl;
    logic        bsy;
    logic        drdy;
    logic        df;
    logic        serv;
    logic        drq;
    logic        errb;
    logic [4:0]  cur;
    logic [31:0] pend;
    logic [31:0] rdy;
    logic        mc_flag;
    logic        cmd_req;
    logic        dma_go;
    logic        flush;
    qdrc_ent_t   o;
    logic [4:0]  o_tag;
  } qdrc_regs_t;

  qdrc_regs_t r_r;
  qdrc_regs_t r_nxt;
  logic       mem_we;
  logic [4:0] mem_waddr;
  logic [4:0] mem_raddr;
  qdrc_ent_t  mem_wdata;
  qdrc_ent_t  mem_rdata;

  // lowest tag waiting for service
  function automatic logic [4:0] pick_low(input logic [31:0] v);
    logic [4:0] p;
    p = 5'h00;
    for (int i = TAG_DEPTH - 1; i >= 0; i--) begin
      if (v[i]) begin
        p = 5'(i);
      end
    end
    return p;
  endfunction

  qdrc_tag_mem u_mem (
    .aclk  (aclk),
    .we    (mem_we),
    .waddr (mem_waddr),
    .wdata (mem_wdata),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  // next-state logic for bus slave, command decode and phase images
  always_comb begin
    logic        qen;
    logic [4:0]  tag;
    logic [4:0]  tagv;
    logic [8:0]  cnt9;
    logic [27:0] lba;
    logic [28:0] last;
    logic        cmd_fire;
    logic [31:0] cur_bit;
    logic [7:0]  ebits;
    r_nxt     = r_r;
    mem_we    = 1'b0;
    mem_waddr = 5'h00;
    mem_raddr = r_r.cur;
    mem_wdata = '0;
    cmd_fire  = 1'b0;
    r_nxt.cmd_req = 1'b0;
    r_nxt.dma_go  = 1'b0;
    r_nxt.flush   = 1'b0;
    qen  = r_r.ctrl[CTRL_QUEUE];
    tag  = qen ? r_r.irr[7:IR_TAG_LSB] : 5'h00;
    tagv = qen ? r_r.cur : 5'h00;
    cnt9 = (r_r.feat == 8'h00) ? SECT_ZERO_CNT : {1'b0, r_r.feat};
    lba  = {r_r.devh[3:0], r_r.ahigh, r_r.amid, r_r.alow};
    last = {1'b0, lba} + {20'h00000, cnt9} - 29'h00000001;
    cur_bit = 32'h00000001 << r_r.cur;
    // MC and MCR reported, MC state cleared when shown
    // ICRC passes through from the engine
    ebits = fail_bits;
    ebits[ER_MC]  = r_r.mc_flag;
    ebits[ER_MCR] = media_chg_req;
    ebits[ER_NM]  = ebits[ER_NM] | no_media;
    // any Ultra DMA error also aborts
    if (fail_bits[ER_ICRC]) begin
      ebits[ER_ABRT] = 1'b1;
    end

    // write address and data may come in either order
    if (s_axi_awvalid && r_r.awready) begin
      r_nxt.awg = 1'b1;
      r_nxt.awa = s_axi_awaddr;
    end
    if (s_axi_wvalid && r_r.wready) begin
      r_nxt.wg  = 1'b1;
      r_nxt.wd  = s_axi_wdata[7:0];
      r_nxt.wbe = s_axi_wstrb[0];
    end
    if (r_r.bvalid && s_axi_bready) begin
      r_nxt.bvalid = 1'b0;
    end
    // register write once both halves are held
    if (r_r.awg && r_r.wg && !r_r.bvalid) begin
      r_nxt.awg    = 1'b0;
      r_nxt.wg     = 1'b0;
      r_nxt.bvalid = 1'b1;
      r_nxt.bresp  = RESP_OKAY;
      // writes while a command is in hand are dropped, not refused
      if (r_r.wbe && r_r.st == S_IDLE) begin
        unique case (r_r.awa)
          OFS_FEAT:  r_nxt.feat  = r_r.wd;
          OFS_IRR:   r_nxt.irr   = r_r.wd;
          OFS_ALOW:  r_nxt.alow  = r_r.wd;
          OFS_AMID:  r_nxt.amid  = r_r.wd;
          OFS_AHIGH: r_nxt.ahigh = r_r.wd;
          OFS_DEVH:  r_nxt.devh  = r_r.wd;
          OFS_CTRL:  r_nxt.ctrl  = r_r.wd;
          OFS_CMD:   cmd_fire    = 1'b1;
          OFS_ERR, OFS_STS: ;
          default:   r_nxt.bresp = RESP_SLVERR;
        endcase
      end else if (!(r_r.awa inside {OFS_FEAT, OFS_IRR, OFS_ALOW, OFS_AMID,
                                     OFS_AHIGH, OFS_DEVH, OFS_CTRL, OFS_CMD,
                                     OFS_ERR, OFS_STS})) begin
        r_nxt.bresp = RESP_SLVERR;
      end
    end
    r_nxt.awready = !r_nxt.awg && !r_nxt.bvalid;
    r_nxt.wready  = !r_nxt.wg && !r_nxt.bvalid;

    // read channel, one outstanding read
    if (s_axi_arvalid && r_r.arready) begin
      r_nxt.arready = 1'b0;
      r_nxt.rvalid  = 1'b1;
      r_nxt.rresp   = RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_IRR:   r_nxt.rd = r_r.irr;
        OFS_ALOW:  r_nxt.rd = r_r.alow;
        OFS_AMID:  r_nxt.rd = r_r.amid;
        OFS_AHIGH: r_nxt.rd = r_r.ahigh;
        OFS_DEVH:  r_nxt.rd = r_r.devh;
        OFS_ERR:   r_nxt.rd = r_r.err;
        OFS_CTRL:  r_nxt.rd = r_r.ctrl;
        OFS_STS:   r_nxt.rd = {r_r.bsy, r_r.drdy, r_r.df, r_r.serv,
                               r_r.drq, 2'b00, r_r.errb};
        OFS_FEAT, OFS_CMD: r_nxt.rd = 8'h00;
        default: begin
          r_nxt.rd    = 8'h00;
          r_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (r_r.rvalid && s_axi_rready) begin
      r_nxt.rvalid  = 1'b0;
      r_nxt.arready = 1'b1;
    end

    // prepared released command raises SERV only
    if (prep_valid && r_r.pend[prep_tag]) begin
      r_nxt.rdy[prep_tag] = 1'b1;
      r_nxt.serv          = 1'b1;
    end

    unique case (r_r.st)
      S_IDLE: begin
        if (cmd_fire) begin
          r_nxt.opc  = r_r.wd;
          r_nxt.bsy  = 1'b1;
          r_nxt.drq  = 1'b0;
          r_nxt.st   = S_CHECK;
        end
      end
      S_CHECK: begin
        r_nxt.bsy  = 1'b0;
        r_nxt.drdy = 1'b1;
        r_nxt.df   = 1'b0;
        r_nxt.drq  = 1'b0;
        r_nxt.errb = 1'b0;
        r_nxt.st   = S_IDLE;
        // reason layout: tag, REL, I/O, C/D
        r_nxt.irr  = {tag, 1'b0, 1'b1, 1'b1};
        r_nxt.serv = |r_nxt.rdy;
        if (r_r.opc == OPC_SERVICE && |r_r.rdy) begin
          r_nxt.cur = pick_low(r_r.rdy);
          mem_raddr = pick_low(r_r.rdy);
          r_nxt.bsy = 1'b1;
          r_nxt.st  = S_LOOK;
        // only the queued read opcode runs
        // abort unsupported, overlap not enabled or tag already queued
        end else if (r_r.opc != OPC_RDQ || !r_r.ctrl[CTRL_OVL] ||
                     r_r.pend[tag]) begin
          r_nxt.err  = 8'h00;
          r_nxt.err[ER_ABRT] = 1'b1;
          r_nxt.errb = 1'b1;
        end else if (r_r.devh[DH_LBA] && last > USER_LBA_LAST) begin
          r_nxt.err  = 8'h00;
          r_nxt.err[ER_IDNF] = 1'b1;
          r_nxt.errb = 1'b1;
        end else if (no_media) begin
          // no medium at issue; engine failure bits do not apply yet
          r_nxt.err          = ERR_NONE;
          r_nxt.err[ER_NM]   = 1'b1;
          r_nxt.err[ER_MC]   = r_r.mc_flag;
          r_nxt.err[ER_MCR]  = media_chg_req;
          r_nxt.errb = 1'b1;
          r_nxt.mc_flag = 1'b0;
        end else begin
          r_nxt.o     = '{lba_mode: r_r.devh[DH_LBA], cnt: cnt9, lba: lba};
          r_nxt.o_tag = tag;
          r_nxt.cur   = tag;
          // straight into transfer when data is at hand
          if (data_now) begin
            r_nxt.dma_go = 1'b1;
            r_nxt.st     = S_DATA;
            // data image, REL if another released command waits
            r_nxt.irr  = {tag, |r_r.pend, 1'b1, 1'b0};
            // DRQ with SERV only for another ready command
            r_nxt.drq  = 1'b1;
          end else begin
            // released now, transfer after a later service
            mem_we    = 1'b1;
            mem_waddr = tag;
            mem_wdata = r_nxt.o;
            r_nxt.pend[tag] = 1'b1;
            r_nxt.cmd_req   = 1'b1;
            // SERV covers only other commands already prepared, never this one
            r_nxt.irr  = {tag, 1'b1, 1'b0, 1'b0};
            r_nxt.serv = |r_nxt.rdy;
          end
        end
      end
      S_LOOK: begin
        // parameters come back from the tag store one cycle on
        r_nxt.o      = mem_rdata;
        r_nxt.o_tag  = r_r.cur;
        r_nxt.dma_go = 1'b1;
        r_nxt.rdy    = r_nxt.rdy & ~cur_bit;
        r_nxt.bsy    = 1'b0;
        r_nxt.drq    = 1'b1;
        r_nxt.st     = S_DATA;
        r_nxt.irr  = {tagv, |(r_r.pend & ~cur_bit), 1'b1, 1'b0};
        // SERV only for another ready command
        r_nxt.serv = |(r_nxt.rdy & ~cur_bit);
      end
      S_DATA: begin
        if (xfer_fail) begin
          // failing address loaded, whole queue dropped
          r_nxt.alow  = fail_addr[7:0];
          r_nxt.amid  = fail_addr[15:8];
          r_nxt.ahigh = fail_addr[23:16];
          r_nxt.devh  = {r_r.devh[7:4], fail_addr[27:24]};
          r_nxt.pend  = 32'h00000000;
          r_nxt.rdy   = 32'h00000000;
          r_nxt.flush = 1'b1;
          r_nxt.err     = ebits;
          r_nxt.errb    = |ebits;
          r_nxt.df      = dev_fault;
          r_nxt.mc_flag = 1'b0;
          r_nxt.drq     = 1'b0;
          r_nxt.drdy    = 1'b1;
          r_nxt.irr     = {tagv, 1'b0, 1'b1, 1'b1};
          r_nxt.serv    = 1'b0;
          r_nxt.st      = S_IDLE;
        end else if (xfer_done) begin
          r_nxt.err  = ERR_NONE;
          r_nxt.irr  = {tagv, 1'b0, 1'b1, 1'b1};
          r_nxt.pend = r_r.pend & ~cur_bit;
          r_nxt.rdy  = r_nxt.rdy & ~cur_bit;
          r_nxt.drq  = 1'b0;
          r_nxt.errb = 1'b0;
          r_nxt.df   = 1'b0;
          r_nxt.drdy = 1'b1;
          r_nxt.serv = |(r_nxt.rdy & ~cur_bit);
          r_nxt.st   = S_IDLE;
        end
      end
    endcase
    // a new media change wins over the clear
    if (media_changed) begin
      r_nxt.mc_flag = 1'b1;
    end
  end

  // single register stage for all state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r_r         <= '0;
      r_r.st      <= S_IDLE;
      r_r.awready <= 1'b1;
      r_r.wready  <= 1'b1;
      r_r.arready <= 1'b1;
      r_r.drdy    <= 1'b1;
      r_r.ctrl    <= CTRL_RST;
      r_r.err     <= ERR_NONE;
    end else begin
      r_r <= r_nxt;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready = r_r.awready;
  assign s_axi_wready  = r_r.wready;
  assign s_axi_bresp   = r_r.bresp;
  assign s_axi_bvalid  = r_r.bvalid;
  assign s_axi_arready = r_r.arready;
  assign s_axi_rdata   = {24'h000000, r_r.rd};
  assign s_axi_rresp   = r_r.rresp;
  assign s_axi_rvalid  = r_r.rvalid;
  assign cmd_req       = r_r.cmd_req;
  assign dma_go        = r_r.dma_go;
  assign queue_flush   = r_r.flush;
  assign dma_tag       = r_r.o_tag;
  assign dma_lba       = r_r.o.lba;
  assign dma_count     = r_r.o.cnt;
  assign dma_lba_mode  = r_r.o.lba_mode;
endmodule
`default_nettype wire

// [qdrc_pkg.sv]
/*
  qdrc_pkg: constants and types of the queued DMA read command block.
  Assumes a 32-bit AXI4-Lite register window with a 6-bit byte address.
*/
`default_nettype none
package qdrc_pkg;
  // register byte offsets, one aligned word each
  localparam logic [5:0] OFS_FEAT  = 6'h00;
  localparam logic [5:0] OFS_IRR   = 6'h04;
  localparam logic [5:0] OFS_ALOW  = 6'h08;
  localparam logic [5:0] OFS_AMID  = 6'h0C;
  localparam logic [5:0] OFS_AHIGH = 6'h10;
  localparam logic [5:0] OFS_DEVH  = 6'h14;
  localparam logic [5:0] OFS_CMD   = 6'h18;
  localparam logic [5:0] OFS_ERR   = 6'h1C;
  localparam logic [5:0] OFS_STS   = 6'h20;
  localparam logic [5:0] OFS_CTRL  = 6'h24;
  // opcodes
  localparam logic [7:0] OPC_RDQ     = 8'hC7;
  localparam logic [7:0] OPC_SERVICE = 8'hA2;
  // status bit positions
  localparam int ST_BSY  = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DF   = 5;
  localparam int ST_SERV = 4;
  localparam int ST_DRQ  = 3;
  localparam int ST_ERR  = 0;
  // error bit positions
  localparam int ER_ICRC = 7;
  localparam int ER_UNC  = 6;
  localparam int ER_MC   = 5;
  localparam int ER_IDNF = 4;
  localparam int ER_MCR  = 3;
  localparam int ER_ABRT = 2;
  localparam int ER_NM   = 1;
  // interrupt reason fields and other positions
  localparam int IR_TAG_LSB = 3;
  localparam int IR_REL     = 2;
  localparam int IR_IO      = 1;
  localparam int IR_CD      = 0;
  localparam int DH_LBA     = 6;
  localparam int CTRL_QUEUE = 0;
  localparam int CTRL_OVL   = 1;
  // reset values and limits
  localparam logic [7:0]  CTRL_RST      = 8'h03;
  localparam logic [7:0]  ERR_NONE      = 8'h00;
  localparam logic [8:0]  SECT_ZERO_CNT = 9'h100;
  localparam logic [28:0] USER_LBA_LAST = 29'h0FFFFFFF;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam int          TAG_DEPTH     = 32;

  typedef enum logic [1:0] {S_IDLE, S_CHECK, S_LOOK, S_DATA} qdrc_state_t;

  // one queued command as kept per tag
  typedef struct packed {
    logic        lba_mode;
    logic [8:0]  cnt;
    logic [27:0] lba;
  } qdrc_ent_t;
endpackage
`default_nettype wire

// [qdrc_tag_mem.sv]
/*
  qdrc_tag_mem: per-tag store of queued command parameters.
  Assumes one write port and one read port on the same clock;
  read data appear from a register one cycle after the address.
*/
`timescale 1ns/1ps
`default_nettype none
module qdrc_tag_mem
  import qdrc_pkg::*;
(
  input  wire logic      aclk,
  input  wire logic      we,
  input  wire logic [4:0] waddr,
  input  var  qdrc_ent_t wdata,
  input  wire logic [4:0] raddr,
  output var  qdrc_ent_t rdata
);
  qdrc_ent_t mem [TAG_DEPTH];

  // no reset: contents are only read for tags marked pending
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

// [qdrc_top_properties.sv]
/*
  qdrc_top_properties: concurrent checks on the ports of qdrc_top.
  Assumes it is bound into qdrc_top and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module qdrc_top_properties
  import qdrc_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [5:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        xfer_fail,
  input wire logic        cmd_req,
  input wire logic        dma_go,
  input wire logic        queue_flush,
  input wire logic [8:0]  dma_count
);
  // one clock domain, reset held low disables all checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write halves taken at one edge
  sequence s_wtake;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rtake;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (s_wtake |-> ##2 s_axi_bvalid) else $error("write answer late");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_read_answer: assert property (s_rtake |=> s_axi_rvalid) else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_unmapped_read: assert property (s_rtake and s_axi_araddr > 6'h24 |=> s_axi_rresp == RESP_SLVERR)
    else $error("unmapped read not refused");
  a_count_range: assert property (dma_go |-> dma_count >= 9'h001 && dma_count <= SECT_ZERO_CNT)
    else $error("sector count out of range");
  a_flush_cause: assert property (queue_flush |-> $past(xfer_fail))
    else $error("queue flushed without failure");
  a_release_or_go: assert property (!(cmd_req && dma_go))
    else $error("release and transfer together");
endmodule
`default_nettype wire

// [qdrc_engine_model.sv]
/*
  qdrc_engine_model: behavioural media engine facing qdrc_top.
  Assumes aclk timing; prepares released tags and ends transfers late.
*/
`timescale 1ns/1ps
`default_nettype none
module qdrc_engine_model (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        cmd_req,
  input  wire logic        dma_go,
  input  wire logic [4:0]  dma_tag,
  input  wire logic        want_direct,
  input  wire logic        want_fail,
  output logic             data_now,
  output logic             prep_valid,
  output logic [4:0]       prep_tag,
  output logic             xfer_done,
  output logic             xfer_fail,
  output logic [7:0]       fail_bits,
  output logic [27:0]      fail_addr,
  output logic             dev_fault
);
  int pcnt;
  int xcnt;
  assign data_now  = want_direct;
  assign fail_bits = 8'h80; // interface crc fault
  assign fail_addr = 28'h0A5B6C7;
  assign dev_fault = want_fail;
  // slow answers so every image can be read back before it moves on
  always @(posedge aclk) begin
    prep_valid <= 1'b0;
    xfer_done  <= 1'b0;
    xfer_fail  <= 1'b0;
    if (!aresetn) begin
      pcnt <= 0;
      xcnt <= 0;
    end else begin
      if (cmd_req) begin
        pcnt     <= 60;
        prep_tag <= dma_tag;
      end else if (pcnt == 1) begin
        pcnt       <= 0;
        prep_valid <= 1'b1;
      end else if (pcnt > 1) pcnt <= pcnt - 1;
      if (dma_go) xcnt <= 40;
      else if (xcnt == 1) begin
        xcnt      <= 0;
        xfer_done <= !want_fail;
        xfer_fail <= want_fail;
      end else if (xcnt > 1) xcnt <= xcnt - 1;
    end
  end
endmodule
`default_nettype wire

// [tb_queued_dma_read_command.sv]
/*
  tb_queued_dma_read_command: register-level tests of qdrc_top.
  Assumes qdrc_engine_model on the far side and one 25 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_queued_dma_read_command;
  import qdrc_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic [5:0] awaddr = 6'h00, araddr = 6'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, rv;
  logic [1:0] bresp, rresp, resp;
  logic awready, wready, bvalid, arready, rvalid;
  logic want_direct = 1'b0, want_fail = 1'b0, media_changed = 1'b0, media_chg_req = 1'b0, no_media = 1'b0;
  logic data_now, prep_valid, xfer_done, xfer_fail, dev_fault, cmd_req, dma_go, queue_flush, dma_lba_mode;
  logic [4:0] prep_tag, dma_tag;
  logic [7:0] fail_bits;
  logic [27:0] fail_addr, dma_lba;
  logic [8:0] dma_count;
  int miscompares = 0, check_count = 0, cyc = 0, go_cnt = 0, req_cnt = 0, fl_cnt = 0, n;
  logic [7:0] ctl_t [4] = '{8'h00, 8'h03, 8'h03, 8'h03};
  logic [7:0] op_t [4]  = '{8'hC7, 8'hC8, 8'hC7, 8'hC7};
  logic [7:0] err_t [4] = '{8'h04, 8'h04, 8'h10, 8'h02};
  always #20 aclk = ~aclk;
  qdrc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .data_now(data_now),
    .prep_valid(prep_valid), .prep_tag(prep_tag), .xfer_done(xfer_done), .xfer_fail(xfer_fail),
    .fail_bits(fail_bits), .fail_addr(fail_addr), .dev_fault(dev_fault), .media_changed(media_changed),
    .media_chg_req(media_chg_req), .no_media(no_media), .cmd_req(cmd_req), .dma_go(dma_go),
    .queue_flush(queue_flush), .dma_tag(dma_tag), .dma_lba(dma_lba), .dma_count(dma_count),
    .dma_lba_mode(dma_lba_mode));
  qdrc_engine_model eng (.aclk(aclk), .aresetn(aresetn), .cmd_req(cmd_req), .dma_go(dma_go),
    .dma_tag(dma_tag), .want_direct(want_direct), .want_fail(want_fail), .data_now(data_now),
    .prep_valid(prep_valid), .prep_tag(prep_tag), .xfer_done(xfer_done), .xfer_fail(xfer_fail),
    .fail_bits(fail_bits), .fail_addr(fail_addr), .dev_fault(dev_fault));
  // event counters, since pulses may land while a bus task waits
  always @(posedge aclk) begin
    go_cnt <= go_cnt + (dma_go === 1'b1);
    req_cnt <= req_cnt + (cmd_req === 1'b1);
    fl_cnt <= fl_cnt + (queue_flush === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // write halves offered together, each released once taken
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp = bresp;
  endtask
  task automatic rd(input logic [5:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rv = rdata;
    resp = rresp;
  endtask
  task automatic cr(input logic [5:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
  endtask
  task automatic wait_sts(input logic [31:0] m, input logic [31:0] v);
    do rd(OFS_STS); while ((rv & m) !== v);
  endtask
  // image is loaded one cycle after the command write takes effect
  task automatic issue(input logic [7:0] f, t, lo, mi, hi, dh, op);
    wait_sts(32'h40, 32'h40);
    wr(OFS_FEAT, f);
    wr(OFS_IRR, t);
    wr(OFS_ALOW, lo);
    wr(OFS_AMID, mi);
    wr(OFS_AHIGH, hi);
    wr(OFS_DEVH, dh);
    wr(OFS_CMD, op);
    repeat (3) @(posedge aclk);
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    cr(OFS_STS, 32'h40);
    cr(OFS_ERR, 32'h00);
    cr(OFS_CTRL, 32'h03);
    rd(6'h28);
    chk(resp, RESP_SLVERR);
    wr(6'h2C, 8'h01);
    chk(resp, RESP_SLVERR);
    $display("test reset done");
    // direct transfer, zero count, lba mode
    want_direct <= 1'b1;
    n = go_cnt;
    issue(8'h00, 8'h28, 8'h11, 8'h22, 8'h33, 8'h44, OPC_RDQ);
    while (go_cnt == n) @(posedge aclk);
    chk(dma_count, 32'h100);
    chk(dma_tag, 32'h05);
    chk(dma_lba, 32'h4332211);
    chk(dma_lba_mode, 32'h1);
    cr(OFS_IRR, 32'h2A);
    cr(OFS_STS, 32'h48);
    wait_sts(32'h88, 32'h00);
    want_direct <= 1'b0;
    cr(OFS_IRR, 32'h2B);
    cr(OFS_ERR, 32'h00);
    cr(OFS_STS, 32'h40);
    $display("test direct done");
    // release, prepare, then service
    n = req_cnt;
    issue(8'h03, 8'h48, 8'h01, 8'h02, 8'h03, 8'h05, OPC_RDQ);
    while (req_cnt == n) @(posedge aclk);
    cr(OFS_IRR, 32'h4C);
    cr(OFS_STS, 32'h40);
    wait_sts(32'h10, 32'h10);
    cr(OFS_IRR, 32'h4C);
    cr(OFS_STS, 32'h50);
    n = go_cnt;
    wr(OFS_CMD, OPC_SERVICE);
    while (go_cnt == n) @(posedge aclk);
    chk(dma_count, 32'h003);
    chk(dma_lba_mode, 32'h0);
    cr(OFS_IRR, 32'h4A);
    cr(OFS_STS, 32'h48);
    wait_sts(32'h88, 32'h00);
    cr(OFS_IRR, 32'h4B);
    $display("test release done");
    // refused commands: overlap off, bad opcode, out of range, no media
    for (int i = 0; i < 4; i++) begin
      wr(OFS_CTRL, ctl_t[i]);
      no_media <= (i == 3);
      issue(8'h02, 8'h18, {8{i == 2}}, {8{i == 2}}, {8{i == 2}}, (i == 2) ? 8'h4F : 8'h40, op_t[i]);
      cr(OFS_ERR, err_t[i]);
      cr(OFS_IRR, (i == 0) ? 32'h03 : 32'h1B);
      cr(OFS_STS, 32'h41);
    end
    wr(OFS_CTRL, 8'h03);
    no_media <= 1'b0;
    $display("test refusals done");
    // duplicate tag, then failing transfer flushes the queue
    n = req_cnt;
    issue(8'h01, 8'h38, 8'h00, 8'h00, 8'h00, 8'h40, OPC_RDQ);
    while (req_cnt == n) @(posedge aclk);
    issue(8'h01, 8'h38, 8'h00, 8'h00, 8'h00, 8'h40, OPC_RDQ);
    cr(OFS_ERR, 32'h04);
    cr(OFS_IRR, 32'h3B);
    wait_sts(32'h10, 32'h10);
    media_chg_req <= 1'b1;
    want_fail <= 1'b1;
    media_changed <= 1'b1;
    @(posedge aclk);
    media_changed <= 1'b0;
    n = fl_cnt;
    wr(OFS_CMD, OPC_SERVICE);
    while (fl_cnt == n) @(posedge aclk);
    repeat (2) @(posedge aclk);
    cr(OFS_ERR, 32'hAC);
    cr(OFS_STS, 32'h61);
    cr(OFS_IRR, 32'h3B);
    cr(OFS_ALOW, 32'hC7);
    cr(OFS_AMID, 32'hB6);
    cr(OFS_AHIGH, 32'hA5);
    $display("test failure done");
    wrap_up();
  end
endmodule
bind qdrc_top qdrc_top_properties u_props (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .xfer_fail(xfer_fail), .cmd_req(cmd_req), .dma_go(dma_go),
  .queue_flush(queue_flush), .dma_count(dma_count));
`default_nettype wire
